// File: mstm_pkg.sv
package mstm_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] MSTM_CTRL_OFF   = 12'h000;
  localparam logic [11:0] MSTM_SMOOTH_OFF = 12'h004;
  localparam logic [11:0] MSTM_CAP_OFF    = 12'h008;
  localparam logic [11:0] MSTM_STD_OFF    = 12'h00c;
  localparam logic [11:0] MSTM_GOP_OFF    = 12'h010;
  localparam logic [11:0] MSTM_OCC_OFF    = 12'h014;
  localparam logic [11:0] MSTM_STAT_OFF   = 12'h018;
  localparam logic [11:0] MSTM_PID_OFF    = 12'h01c;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int MSTM_CTRL_PS_BIT     = 0;   // 1 = program stream
  localparam int MSTM_CTRL_STILL_BIT  = 1;   // still-picture stream
  localparam int MSTM_CTRL_CLR_BIT    = 2;   // write 1 clears violations
  localparam int MSTM_STD_LEAK_BIT    = 0;
  localparam int MSTM_STD_VIDEO_BIT   = 1;
  localparam int MSTM_GOP_CLOSED_BIT  = 0;
  localparam int MSTM_GOP_UNIF_BIT    = 1;
  localparam int MSTM_GOP_LEN_LSB     = 2;
  localparam int MSTM_FIELD_W         = 22;
  localparam int MSTM_GOP_LEN_W       = 14;
  localparam int MSTM_PID_W           = 13;

  // ****************************************************************
  // violation flag positions
  // ****************************************************************
  localparam int MSTM_V_OVF  = 0;
  localparam int MSTM_V_SCR  = 1;
  localparam int MSTM_V_PCR  = 2;
  localparam int MSTM_V_PAIR = 3;
  localparam int MSTM_V_ESCR = 4;
  localparam int MSTM_V_PTS  = 5;
  localparam int MSTM_V_W    = 6;

  // ****************************************************************
  // descriptor placement and drain method
  // ****************************************************************
  typedef enum logic [1:0] {
    MSTM_LOC_OTHER   = 2'b00,
    MSTM_LOC_ES      = 2'b01,
    MSTM_LOC_PROGRAM = 2'b10
  } mstm_loc_e;

  typedef enum logic [1:0] {
    MSTM_DRAIN_NONE  = 2'b00,
    MSTM_DRAIN_LEAK  = 2'b01,
    MSTM_DRAIN_DELAY = 2'b10
  } mstm_drain_e;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam longint MSTM_CLK_HZ        = 100000000;
  localparam longint MSTM_LIMIT_100MS   = 100;   // ms
  localparam longint MSTM_LIMIT_700MS   = 700;   // ms
  localparam longint MSTM_PCR_CYC       = MSTM_CLK_HZ / 1000 * MSTM_LIMIT_100MS;
  localparam longint MSTM_LONG_CYC      = MSTM_CLK_HZ / 1000 * MSTM_LIMIT_700MS;
  localparam int     MSTM_RATE_UNIT     = 400;   // bits/s per unit
  localparam int     MSTM_CNT_W         = 32;
  localparam logic [15:0] MSTM_VBV_NONE = 16'hffff;

endpackage : mstm_pkg

// File: mstm_monitor.sv
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module mstm_monitor #(
  parameter longint PCR_LIMIT_CYC  = mstm_pkg::MSTM_PCR_CYC,
  parameter longint LONG_LIMIT_CYC = mstm_pkg::MSTM_LONG_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // descriptor from parser
  input  wire logic        desc_valid,
  input  wire logic [1:0]  desc_loc,
  input  wire logic [21:0] desc_drain_rate,
  input  wire logic [21:0] desc_capacity,
  input  wire logic [12:0] desc_pid,
  input  wire logic [12:0] desc_pmt_pid,
  // stream bytes
  input  wire logic        byte_valid,
  input  wire logic [12:0] byte_pid,
  input  wire logic        byte_is_pmt,
  input  wire logic        byte_is_es,
  // timing events
  input  wire logic        scr_event,
  input  wire logic        pcr_event,
  input  wire logic        pcr_discont,
  input  wire logic        escr_event,
  input  wire logic        pts_event,
  input  wire logic        decode_discont,
  input  wire logic [15:0] vbv_delay,
  // status
  output var  logic [1:0]  drain_method,
  output var  logic [5:0]  violation
);
  import mstm_pkg::*;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic                  ps_mode_r;
  logic                  still_r;
  logic [21:0]           drain_rate_r;
  logic [21:0]           capacity_r;
  logic [12:0]           route_pid_r;
  logic [12:0]           pmt_pid_r;
  logic                  route_prog_r;
  logic                  route_en_r;
  logic                  leak_sel_r;
  logic                  is_video_r;
  logic                  closed_gop_r;
  logic                  uniform_gop_r;
  logic [13:0]           gop_len_r;
  logic [31:0]           occ_r;
  logic [31:0]           credit_r;
  logic [MSTM_CNT_W-1:0] now_r;
  logic [MSTM_CNT_W-1:0] scr_t_r;
  logic [MSTM_CNT_W-1:0] pcr_t_r;
  logic [MSTM_CNT_W-1:0] escr_t_r;
  logic [MSTM_CNT_W-1:0] pts_t_r;
  logic [3:0]            seen_r;      // first event seen per check
  logic [1:0]            pcr_cnt_r;
  logic [5:0]            viol_r;
  logic                  clr;
  logic                  wr_en;
  logic                  rd_en;
  logic                  in_byte;
  logic                  out_byte;
  logic [5:0]            set_v;
  logic [31:0]           rate_bps;
  logic                  desc_ok;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign clr   = wr_en && (paddr == MSTM_CTRL_OFF) && pwdata[MSTM_CTRL_CLR_BIT];

  // ****************************************************************
  // apb: zero wait state, unmapped addresses answer pslverr
  // ****************************************************************
  // read data is caught in the setup cycle so it stands through the access cycle;
  // misaligned or out-of-range accesses answer an error and change nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr > MSTM_PID_OFF || paddr[1:0] != 2'b00);
      if (rd_en) begin
        if (paddr == MSTM_CTRL_OFF)
          prdata <= {30'h0, still_r, ps_mode_r};
        else if (paddr == MSTM_SMOOTH_OFF)
          prdata <= {10'h0, drain_rate_r};
        else if (paddr == MSTM_CAP_OFF)
          prdata <= {10'h0, capacity_r};
        else if (paddr == MSTM_STD_OFF)
          prdata <= {30'h0, is_video_r, leak_sel_r};
        else if (paddr == MSTM_GOP_OFF)
          prdata <= {16'h0, gop_len_r, uniform_gop_r, closed_gop_r};
        else if (paddr == MSTM_OCC_OFF)
          prdata <= occ_r;
        else if (paddr == MSTM_STAT_OFF)
          prdata <= {24'h0, drain_method, viol_r};
        else if (paddr == MSTM_PID_OFF)
          prdata <= {3'h0, pmt_pid_r, 1'b0, route_en_r, route_prog_r, route_pid_r};
        else
          prdata <= 32'h0;
      end
    end
  end

  // software-owned configuration
  // writes land in the access cycle, the edge at which pready is seen high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_mode_r     <= 1'b0;
      still_r       <= 1'b0;
      leak_sel_r    <= 1'b0;
      is_video_r    <= 1'b0;
      closed_gop_r  <= 1'b0;
      uniform_gop_r <= 1'b0;
      gop_len_r     <= 14'h0;
    end else if (wr_en) begin
      if (paddr == MSTM_CTRL_OFF) begin
        ps_mode_r <= pwdata[MSTM_CTRL_PS_BIT];
        still_r   <= pwdata[MSTM_CTRL_STILL_BIT];
      end else if (paddr == MSTM_STD_OFF) begin
        leak_sel_r <= pwdata[MSTM_STD_LEAK_BIT];
        is_video_r <= pwdata[MSTM_STD_VIDEO_BIT];
      end else if (paddr == MSTM_GOP_OFF) begin
        closed_gop_r  <= pwdata[MSTM_GOP_CLOSED_BIT];
        uniform_gop_r <= pwdata[MSTM_GOP_UNIF_BIT];
        gop_len_r     <= pwdata[MSTM_GOP_LEN_LSB +: MSTM_GOP_LEN_W];
      end
    end
  end

  // ****************************************************************
  // smoothing descriptor capture
  // ****************************************************************
  // only table-carried descriptors count; a stray copy elsewhere is dropped
  assign desc_ok = desc_valid &&
                   (desc_loc == MSTM_LOC_ES || desc_loc == MSTM_LOC_PROGRAM);

  // a later table copy simply replaces the earlier one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drain_rate_r <= 22'h0;
      capacity_r   <= 22'h0;
      route_pid_r  <= 13'h0;
      pmt_pid_r    <= 13'h0;
      route_prog_r <= 1'b0;
      route_en_r   <= 1'b0;
    end else if (desc_ok) begin
      drain_rate_r <= desc_drain_rate;
      capacity_r   <= desc_capacity;
      route_pid_r  <= desc_pid;
      pmt_pid_r    <= desc_pmt_pid;
      route_prog_r <= (desc_loc == MSTM_LOC_PROGRAM);
      route_en_r   <= 1'b1;
    end
  end

  // ****************************************************************
  // smoothing buffer model
  // ****************************************************************
  // program stream: all pes bytes; element scope: one pid;
  // program scope: every elementary pid plus the pmt pid
  // nothing counts until a table descriptor has enabled routing
  always_comb begin
    if (ps_mode_r)
      in_byte = byte_valid && route_en_r;
    else if (route_prog_r)
      in_byte = byte_valid && route_en_r &&
                (byte_is_es || byte_is_pmt || byte_pid == pmt_pid_r);
    else
      in_byte = byte_valid && route_en_r && byte_pid == route_pid_r;
  end

  // drain credit in bits per second: one byte leaves per 8*clk_hz credit
  assign rate_bps = 32'(drain_rate_r) * 32'(MSTM_RATE_UNIT);
  assign out_byte = (occ_r != 32'h0) && (credit_r >= 32'(MSTM_CLK_HZ * 8));

  // fractional accumulator keeps the long-run rate exact
  // credit builds only while data waits, so an idle buffer cannot bank a burst
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      credit_r <= 32'h0;
    else if (occ_r == 32'h0)
      credit_r <= 32'h0;
    else if (out_byte)
      credit_r <= credit_r - 32'(MSTM_CLK_HZ * 8) + rate_bps;
    else
      credit_r <= credit_r + rate_bps;
  end

  // occupancy: one in and one out cancel, so no byte is lost
  // occupancy may pass capacity: the overflow flag reports it, no byte is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      occ_r <= 32'h0;
    else if (in_byte && !out_byte)
      occ_r <= occ_r + 32'h1;
    else if (out_byte && !in_byte)
      occ_r <= occ_r - 32'h1;
  end

  // ****************************************************************
  // decoder-model drain method
  // ****************************************************************
  // delay values are watched live; without leak selected, the all-ones code keeps the method at none
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      drain_method <= MSTM_DRAIN_NONE;
    else if (ps_mode_r || !is_video_r)
      drain_method <= MSTM_DRAIN_NONE;
    else if (leak_sel_r)
      drain_method <= MSTM_DRAIN_LEAK;
    else if (vbv_delay != MSTM_VBV_NONE)
      drain_method <= MSTM_DRAIN_DELAY;
    else
      drain_method <= MSTM_DRAIN_NONE;
  end

  // ****************************************************************
  // spacing checks
  // ****************************************************************
  // wraparound is harmless: the limits sit far below 2**32 cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      now_r <= '0;
    else
      now_r <= now_r + 1'b1;
  end

  // time of the last event of each kind; a discontinuity restarts arming
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scr_t_r  <= '0;
      pcr_t_r  <= '0;
      escr_t_r <= '0;
      pts_t_r  <= '0;
      seen_r   <= 4'h0;
    end else begin
      if (scr_event) begin
        scr_t_r   <= now_r;
        seen_r[0] <= 1'b1;
      end
      if (pcr_discont) begin
        seen_r[1] <= 1'b0;                                                   // new timebase
      end else if (pcr_event) begin
        pcr_t_r   <= now_r;
        seen_r[1] <= 1'b1;
      end
      if (escr_event) begin
        escr_t_r  <= now_r;
        seen_r[2] <= 1'b1;
      end
      if (decode_discont) begin
        seen_r[3] <= 1'b0;
      end else if (pts_event) begin
        pts_t_r   <= now_r;
        seen_r[3] <= 1'b1;
      end
    end
  end

  // pcr count since the last discontinuity, saturating at two
  // limitation: a discontinuity before any reference also reports a missing pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pcr_cnt_r <= 2'h0;
    else if (pcr_discont)
      pcr_cnt_r <= 2'h0;
    else if (pcr_event && pcr_cnt_r != 2'h2)
      pcr_cnt_r <= pcr_cnt_r + 2'h1;
  end

  // each spacing check waits for its first event, so reset is never a false start there
  always_comb begin
    set_v             = 6'h0;
    set_v[MSTM_V_OVF] = in_byte && !out_byte && (occ_r >= 32'(capacity_r));
    set_v[MSTM_V_SCR] = ps_mode_r && scr_event && seen_r[0] &&
                        (now_r - scr_t_r) > MSTM_CNT_W'(LONG_LIMIT_CYC);
    set_v[MSTM_V_PCR] = !ps_mode_r && pcr_event && !pcr_discont && seen_r[1] &&
                        (now_r - pcr_t_r) > MSTM_CNT_W'(PCR_LIMIT_CYC);
    set_v[MSTM_V_PAIR] = pcr_discont && pcr_cnt_r != 2'h2;
    set_v[MSTM_V_ESCR] = escr_event && seen_r[2] &&
                         (now_r - escr_t_r) > MSTM_CNT_W'(LONG_LIMIT_CYC);
    set_v[MSTM_V_PTS] = !still_r && pts_event && !decode_discont && seen_r[3] &&
                        (now_r - pts_t_r) > MSTM_CNT_W'(LONG_LIMIT_CYC);
  end

  // ****************************************************************
  // status outputs
  // ****************************************************************
  // sticky flags: a new event in the clear cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      viol_r <= 6'h0;
    else
      viol_r <= (clr ? 6'h0 : viol_r) | set_v;
  end

  // pin copy of the flags, so the output comes straight from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      violation <= 6'h0;
    else
      violation <= (clr ? 6'h0 : viol_r) | set_v;
  end

endmodule : mstm_monitor
`default_nettype wire

// File: mstm_chk_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module mstm_chk
  import mstm_pkg::*;
#(
  parameter longint PCR_LIMIT_CYC = MSTM_PCR_CYC
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // stream and events
  input wire logic        byte_valid,
  input wire logic        scr_event,
  input wire logic        pcr_event,
  input wire logic        pcr_discont,
  input wire logic        pts_event,
  // status
  input wire logic [1:0]  drain_method,
  input wire logic [5:0]  violation
);
  // ****************************************************************
  // helper logic
  // ****************************************************************
  logic [31:0] gap_r;
  logic        armed_r;
  logic        clr_w;
  // cycles since last clock reference; a discontinuity disarms the check unless a reference arrives in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r   <= '0;
      armed_r <= 1'b0;
    end else begin
      gap_r   <= pcr_event ? 32'h0 : gap_r + 32'h1;
      armed_r <= pcr_event | (armed_r & ~pcr_discont);
    end
  end
  // clear strobe takes effect at the edge where pready is sampled
  assign clr_w = psel & penable & pready & pwrite & (paddr == MSTM_CTRL_OFF)
               & pwdata[MSTM_CTRL_CLR_BIT];
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_one_wait: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb access not answered in one cycle");
  a_unmapped_err: assert property (psel && penable && pready
    && (paddr > 12'h01c || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped access without error");
  a_flags_sticky: assert property (|($past(violation) & ~violation) |-> $past(clr_w))
    else $error("violation flag fell without clear");
  a_pcr_late: assert property (pcr_event && armed_r && gap_r > PCR_LIMIT_CYC
    |=> violation[MSTM_V_PCR]) else $error("late clock reference not flagged");
  a_pcr_cause: assert property ($rose(violation[MSTM_V_PCR]) |-> $past(pcr_event))
    else $error("reference flag without event");
  a_pair_cause: assert property ($rose(violation[MSTM_V_PAIR]) |-> $past(pcr_discont))
    else $error("pair flag without discontinuity");
  a_scr_cause: assert property ($rose(violation[MSTM_V_SCR]) |-> $past(scr_event))
    else $error("pack reference flag without event");
  a_pts_cause: assert property ($rose(violation[MSTM_V_PTS]) |-> $past(pts_event))
    else $error("stamp flag without event");
  a_ovf_cause: assert property ($rose(violation[MSTM_V_OVF]) |-> $past(byte_valid))
    else $error("overflow flag without byte");
  a_drain_legal: assert property (drain_method != 2'b11)
    else $error("illegal drain method");
  // main scenarios reached
  cover property ($rose(violation[MSTM_V_PCR]));
  cover property ($rose(violation[MSTM_V_OVF]));
  cover property (pready && pslverr);
endmodule : mstm_chk

bind mstm_monitor mstm_chk #(.PCR_LIMIT_CYC(PCR_LIMIT_CYC)) chk_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .byte_valid, .scr_event, .pcr_event, .pcr_discont, .pts_event,
  .drain_method, .violation
);
`default_nettype wire

// File: mstm_parser_model.sv
`timescale 1ns/100ps
`default_nettype none
module mstm_parser_model (
  // clock
  input  wire logic        pclk,
  // descriptor and bytes
  output var  logic        desc_valid,
  output var  logic [1:0]  desc_loc,
  output var  logic [21:0] desc_drain_rate,
  output var  logic [21:0] desc_capacity,
  output var  logic [12:0] desc_pid,
  output var  logic [12:0] desc_pmt_pid,
  output var  logic        byte_valid,
  output var  logic [12:0] byte_pid,
  output var  logic        byte_is_pmt,
  output var  logic        byte_is_es,
  // events
  output var  logic [5:0]  ev,
  output var  logic [15:0] vbv_delay
);
  // idle outputs; released fields other than desc_loc and desc_pmt_pid show inverted data, not the last value
  initial begin
    desc_valid = 1'b0;
    byte_valid = 1'b0;
    ev         = '0;
    vbv_delay  = 16'hffff;
  end
  // one descriptor per call, fields fixed while it stands
  task send_desc(input logic [1:0] loc, input logic [21:0] rate, cap,
                 input logic [12:0] pid, pmt);
    @(posedge pclk);
    desc_valid      <= 1'b1;
    desc_loc        <= loc;
    desc_drain_rate <= rate;
    desc_capacity   <= cap;
    desc_pid        <= pid;
    desc_pmt_pid    <= pmt;
    @(posedge pclk);
    desc_valid      <= 1'b0;
    desc_drain_rate <= ~rate;
    desc_capacity   <= ~cap;
    desc_pid        <= ~pid;
  endtask : send_desc
  // one byte per call; occupancy kept legal unless the bench overfills
  task send_byte(input logic [12:0] pid, input logic pmt, es);
    @(posedge pclk);
    byte_valid  <= 1'b1;
    byte_pid    <= pid;
    byte_is_pmt <= pmt;
    byte_is_es  <= es;
    @(posedge pclk);
    byte_valid  <= 1'b0;
    byte_pid    <= ~pid;
    byte_is_pmt <= ~pmt;
    byte_is_es  <= ~es;
  endtask : send_byte
  // one-cycle pulse at the last byte of a base field
  task pulse(input int k);
    @(posedge pclk);
    ev <= 6'(1 << k);
    @(posedge pclk);
    ev    <= '0;
  endtask : pulse
  task set_vbv(input logic [15:0] v);
    @(posedge pclk);
    vbv_delay <= v;
  endtask : set_vbv
endmodule : mstm_parser_model
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import mstm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        desc_valid, byte_valid, byte_is_pmt, byte_is_es;
  logic [1:0]  desc_loc, drain_method;
  logic [21:0] desc_drain_rate, desc_capacity;
  logic [12:0] desc_pid, desc_pmt_pid, byte_pid;
  logic [5:0]  ev, violation;
  logic [15:0] vbv_delay;
  int          bad_count, compares;
  int          cyc = 0;
  // ****************************************************************
  // clock, design and upstream model
  // ****************************************************************
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  mstm_monitor #(.PCR_LIMIT_CYC(100), .LONG_LIMIT_CYC(700)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .desc_valid, .desc_loc, .desc_drain_rate, .desc_capacity, .desc_pid,
    .desc_pmt_pid, .byte_valid, .byte_pid, .byte_is_pmt, .byte_is_es,
    .scr_event(ev[0]), .pcr_event(ev[1]), .pcr_discont(ev[2]), .escr_event(ev[3]),
    .pts_event(ev[4]), .decode_discont(ev[5]), .vbv_delay, .drain_method, .violation
  );
  mstm_parser_model par_u (
    .pclk, .desc_valid, .desc_loc, .desc_drain_rate, .desc_capacity, .desc_pid,
    .desc_pmt_pid, .byte_valid, .byte_pid, .byte_is_pmt, .byte_is_es, .ev, .vbv_delay
  );
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task results;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task cmp(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // one apb transfer; request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    cmp({31'h0, e}, 32'h0);
  endtask : wr
  // masked read; error expected exactly for addresses above 12'h01c
  task rd(input logic [11:0] a, input logic [31:0] m, exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    cmp(r & m, exp);
    cmp({31'h0, e}, {31'h0, a > 12'h01c});
  endtask : rd
  task wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_cyc
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_reset;
    for (int a = 0; a <= 32'h1c; a += 4) rd(a[11:0], 32'hffffffff, 32'h0);
    rd(12'h020, 32'h0, 32'h0);
  endtask : t_reset
  task t_desc;
    par_u.send_desc(MSTM_LOC_OTHER, 22'h3fffff, 22'h3fffff, 13'h0100, 13'h0020);
    rd(MSTM_SMOOTH_OFF, 32'hffffffff, 32'h0);
    par_u.send_desc(MSTM_LOC_ES, 22'd1000, 22'h3fffff, 13'h0100, 13'h0020);
    rd(MSTM_SMOOTH_OFF, 32'hffffffff, 32'd1000);
    rd(MSTM_CAP_OFF, 32'hffffffff, 32'h3fffff);
    rd(MSTM_PID_OFF, 32'h7fff, 32'h4100);
  endtask : t_desc
  // 1000 units give 400000 bit/s: one byte leaves every 2000 cycles
  task t_route;
    for (int i = 0; i < 4; i++) par_u.send_byte(13'h0100, 1'b0, 1'b0);
    par_u.send_byte(13'h0101, 1'b0, 1'b1);
    rd(MSTM_OCC_OFF, 32'hffffffff, 32'd4);
    wait_cyc(9000);
    rd(MSTM_OCC_OFF, 32'hffffffff, 32'd0);
  endtask : t_route
  task t_ovf;
    par_u.send_desc(MSTM_LOC_PROGRAM, 22'd1000, 22'd2, 13'h0000, 13'h0020);
    par_u.send_byte(13'h0200, 1'b0, 1'b1);
    par_u.send_byte(13'h0020, 1'b1, 1'b0);
    rd(MSTM_OCC_OFF, 32'hffffffff, 32'd2);
    rd(MSTM_STAT_OFF, 32'h3f, 32'h0);
    par_u.send_byte(13'h0201, 1'b0, 1'b1);
    rd(MSTM_STAT_OFF, 32'h3f, 32'h1);
    wait_cyc(5000);
    rd(MSTM_STAT_OFF, 32'h3f, 32'h1);
    cmp({26'h0, violation}, 32'h1);
    wr(MSTM_CTRL_OFF, 32'h4);
    rd(MSTM_STAT_OFF, 32'h3f, 32'h0);
  endtask : t_ovf
  task dm(input logic [31:0] ctl, std, input logic [15:0] vbv, input logic [1:0] x);
    wr(MSTM_CTRL_OFF, ctl);
    wr(MSTM_STD_OFF, std);
    par_u.set_vbv(vbv);
    rd(MSTM_STAT_OFF, 32'hc0, {24'h0, x, 6'h0});
    cmp({30'h0, drain_method}, {30'h0, x});
  endtask : dm
  task t_drain;
    dm(32'h0, 32'h3, 16'h1234, MSTM_DRAIN_LEAK);
    dm(32'h0, 32'h2, 16'h1234, MSTM_DRAIN_DELAY);
    dm(32'h0, 32'h2, 16'hffff, MSTM_DRAIN_NONE);
    dm(32'h1, 32'h3, 16'h1234, MSTM_DRAIN_NONE);
    dm(32'h0, 32'h1, 16'h1234, MSTM_DRAIN_NONE);
  endtask : t_drain
  task t_gop;
    wr(MSTM_GOP_OFF, 32'hffff);
    rd(MSTM_GOP_OFF, 32'hffff, 32'hffff);
    wr(MSTM_GOP_OFF, 32'h5);
    rd(MSTM_GOP_OFF, 32'hffff, 32'h5);
  endtask : t_gop
  // reference limit set to 100 cycles
  task t_pcr;
    par_u.pulse(1);
    wait_cyc(50);
    par_u.pulse(1);
    rd(MSTM_STAT_OFF, 32'h3f, 32'h0);
    wait_cyc(150);
    par_u.pulse(1);
    rd(MSTM_STAT_OFF, 32'h3f, 32'h4);
    wr(MSTM_CTRL_OFF, 32'h4);
    par_u.pulse(2);
    rd(MSTM_STAT_OFF, 32'h3f, 32'h0);
    par_u.pulse(1);
    par_u.pulse(2);
    rd(MSTM_STAT_OFF, 32'h3f, 32'h8);
    wr(MSTM_CTRL_OFF, 32'h4);
  endtask : t_pcr
  // long limit set to 700 cycles; events 0, 3, 4 map to flags 1, 4, 5
  task t_long;
    int k;
    int b;
    // pack references are only checked in program stream mode
    wr(MSTM_CTRL_OFF, 32'h1);
    for (int i = 0; i < 3; i++) begin
      k = (i == 0) ? 0 : i + 2;
      b = (i == 0) ? 1 : i + 3;
      par_u.pulse(k);
      wait_cyc(600);
      par_u.pulse(k);
      rd(MSTM_STAT_OFF, 32'h3f, 32'h0);
      wait_cyc(800);
      par_u.pulse(k);
      rd(MSTM_STAT_OFF, 32'h3f, 32'h1 << b);
      wr(MSTM_CTRL_OFF, 32'h4);
    end
    par_u.pulse(5);
    wait_cyc(800);
    par_u.pulse(4);
    rd(MSTM_STAT_OFF, 32'h3f, 32'h0);
    wr(MSTM_CTRL_OFF, 32'h2);
    wait_cyc(800);
    par_u.pulse(4);
    rd(MSTM_STAT_OFF, 32'h3f, 32'h0);
  endtask : t_long
  // ****************************************************************
  // main sequence and hang guard
  // ****************************************************************
  initial begin
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    bad_count = 0;
    compares  = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_desc;
    t_route;
    t_ovf;
    t_drain;
    t_gop;
    t_pcr;
    t_long;
    results;
  end
  // a run far past the expected length counts as a mismatch
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      results;
    end
  end
endmodule : tb_top
`default_nettype wire
